// [rtl/odpc_regs.vh]
// constants for the otg detect and power-on reset control block
`ifndef ODPC_REGS_VH
`define ODPC_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ODPC_OFS_CTRL        8'h00
`define ODPC_OFS_STATUS      8'h04
`define ODPC_OFS_REPORTED    8'h08
`define ODPC_OFS_CMD         8'h0C

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define ODPC_CTRL_ID_PU      0
`define ODPC_CTRL_BLEED      1
`define ODPC_CTRL_PRECHG     2
`define ODPC_CTRL_EXT_DRV    3
`define ODPC_CTRL_MODE_LO    4
`define ODPC_CTRL_MODE_HI    5
`define ODPC_CTRL_W          6
`define ODPC_CTRL_RESET      6'h00

// ---------------------------------------------------------------
// command register fields
// ---------------------------------------------------------------
`define ODPC_CMD_LINK_RST    0
`define ODPC_CMD_INT_CLR     1

// ---------------------------------------------------------------
// data bus modes
// ---------------------------------------------------------------
`define ODPC_MODE_SYNC       2'h0
`define ODPC_MODE_LOWPWR     2'h1
`define ODPC_MODE_SER3       2'h2
`define ODPC_MODE_SER6       2'h3

// ---------------------------------------------------------------
// status word layout (also the reported snapshot)
// ---------------------------------------------------------------
`define ODPC_ST_ID_GROUNDED_FLAG       0
`define ODPC_ST_VBUS_VALID   1
`define ODPC_ST_SESS_VALID   2
`define ODPC_ST_SESSION_END_FLAG     3
`define ODPC_ST_FAULT        4
`define ODPC_ST_W            5
`define ODPC_ST_PHY_RST      5
`define ODPC_ST_SUPPLY_RAMP_RESET_N         6
`define ODPC_ST_INT          7
`define ODPC_ST_PEND         8

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define ODPC_CLK_PERIOD_NS   40
`define ODPC_PHY_RST_MIN_NS  40000
`define ODPC_PHY_RST_CYC     ((`ODPC_PHY_RST_MIN_NS + `ODPC_CLK_PERIOD_NS - 1) / `ODPC_CLK_PERIOD_NS)
`define ODPC_CNT_W           10

`endif

// [rtl/odpc_sync.v]
// two-stage level synchroniser, one pair of flops per bit
`timescale 1ns/1ps
module odpc_sync
#(
   parameter W = 1
)
(
   // clock and reset
   input  wire         hclk,
   input  wire         hresetn,
   // levels
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   reg [W-1:0] meta_q;
   reg [W-1:0] stab_q;

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               meta_q[i] <= 1'b0;
               stab_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= async_in[i];
               stab_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = stab_q;

endmodule

// [rtl/odpc_por.v]
// supply-ramp reset and stretched phy reset sequencer
`timescale 1ns/1ps
`include "odpc_regs.vh"
module odpc_por
(
   // clock and reset
   input  wire hclk,
   input  wire hresetn,
   // synchronised regulator comparator, high above trigger
   input  wire vcc3v3_above,
   // resets out
   output wire supply_ramp_reset_n,
   output wire phy_reset
);

   reg                   supply_ramp_reset_n_q;
   reg                   phy_rst_q;
   reg [`ODPC_CNT_W-1:0] hold_q;
   reg [`ODPC_CNT_W-1:0] hold_d;
   reg                   phy_rst_d;

   // full-width count first, then cut to the counter on purpose
   localparam [31:0]            HOLD_CYC  = `ODPC_PHY_RST_CYC - 1;
   localparam [`ODPC_CNT_W-1:0] HOLD_LAST = HOLD_CYC[`ODPC_CNT_W-1:0];

   // ---------------------------------------------------------------
   // supply_ramp_reset_n follows the comparator; any dip restarts the sequence
   // ---------------------------------------------------------------
   always @*
   begin
      hold_d    = hold_q;
      phy_rst_d = phy_rst_q;
      if (!supply_ramp_reset_n_q)
      begin
         hold_d    = {`ODPC_CNT_W{1'b0}};
         phy_rst_d = 1'b1;                                  // R2
      end
      else if (phy_rst_q)
      begin
         if (hold_q == HOLD_LAST)
            phy_rst_d = 1'b0;                               // R2
         else
            hold_d = hold_q + 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         supply_ramp_reset_n_q    <= 1'b0;
         phy_rst_q <= 1'b1;
         hold_q    <= {`ODPC_CNT_W{1'b0}};
      end
      else
      begin
         supply_ramp_reset_n_q    <= vcc3v3_above;                         // R1 R3
         phy_rst_q <= phy_rst_d;
         hold_q    <= hold_d;
      end
   end

   assign supply_ramp_reset_n = supply_ramp_reset_n_q;
   assign phy_reset           = phy_rst_q;

endmodule

// [rtl/odpc_top.v]
// otg detection, power-on reset control and ulpi status reporting
// Function
// R1: supply-ramp reset low until supplies ramped
// R2: phy reset held at least 40 us
// R3: regulator comparator at 2.0 V releases reset
// R4: link sends reset command after clock starts
// R5: id result valid only with pull-up enabled
// R6: id change reported by rx cmd or interrupt
// R7: id grounded flag 1 for b, 0 for a
// R8: link role follows sensed id level
// R9: weak id pull-up while sense pull-up off
// R10: vbus below valid is fault, ignored at power-up
// R11: session-valid reports session start and completion
// R12: session-end flags vbus below end threshold
// R13: srp bleeds first, then precharges vbus; here both are plain control bits and the order is left to link software
// R14: link drives data low while idle
// R15: four sdr bus modes, no ddr
// R16: chip select high tri-states data pins
// R17: external fault input accepted in host role
// R18: link clears external drive on lost valid
// R19: two-stage sync before compare with reported
// R20: each change reported once, rx cmd or interrupt
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "odpc_regs.vh"
module odpc_top
(
   // ahb-lite clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // ahb-lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   // analog comparators and sense inputs
   input  wire        vcc3v3_above_por,
   input  wire        id_pin_level,
   input  wire        vbus_valid_cmp,
   input  wire        sess_valid_cmp,
   input  wire        session_end_flag_cmp,
   input  wire        fault_in,
   input  wire [1:0]  linestate,
   // ulpi pins
   input  wire        chip_select_n,
   input  wire        stp,
   input  wire [7:0]  ulpi_data_in,
   output wire [7:0]  ulpi_data_out,
   output wire        ulpi_data_oe_n,
   output wire        dir_out,
   output wire        dir_oe_n,
   output wire        nxt_out,
   output wire        nxt_oe_n,
   // analog controls
   output wire        id_sense_pullup_enable,
   output wire        id_weak_pullup_enable,
   output wire        vbus_bleed_enable,
   output wire        vbus_precharge_enable,
   output wire        vbus_switch_enable_out,
   // resets and status
   output wire        supply_ramp_reset_n,
   output wire        phy_reset,
   output wire        status_int
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_TURN = 2'h1;
   localparam [1:0] S_CMD  = 2'h2;
   localparam [1:0] S_BACK = 2'h3;

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   reg  [`ODPC_CTRL_W-1:0] ctrl_q;
   reg  [`ODPC_CTRL_W-1:0] ctrl_d;
   reg  [`ODPC_ST_W-1:0]   rep_q;
   reg  [`ODPC_ST_W-1:0]   rep_d;
   reg                     int_q;
   reg                     int_d;
   reg  [1:0]              st_q;
   reg  [1:0]              st_d;
   reg  [7:0]              dout_q;
   reg  [7:0]              dout_d;
   reg                     lp_turn_q;
   reg                     wr_q;
   reg  [7:0]              ofs_q;
   reg  [31:0]             rdata_q;
   reg  [31:0]             rdata_d;
   wire [6:0]              sync_lvl;
   wire                    sync_por;
   wire [`ODPC_ST_W-1:0]   cur;
   wire                    id_ok;
   wire                    pend;
   wire                    link_idle;
   wire                    sync_mode;
   wire                    lp_mode;
   wire                    acc;
   wire                    wr_ctrl;
   wire                    wr_cmd;
   wire                    link_rst;
   wire                    int_clr;
   wire                    rep_set;
   wire [1:0]              mode;
   wire [7:0]              rx_byte;

   // ---------------------------------------------------------------
   // offset decode, shared by address and data phases
   // ---------------------------------------------------------------
   function is_ofs;
      input [7:0] a;
      input [7:0] o;
      begin
         is_ofs = (a == o);
      end
   endfunction

   // ---------------------------------------------------------------
   // synchronisers and power-on sequencing
   // ---------------------------------------------------------------
   odpc_sync #(.W(7)) u_sync
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in ({vcc3v3_above_por, linestate, fault_in,
                  session_end_flag_cmp, sess_valid_cmp, vbus_valid_cmp}),
      .sync_out ({sync_por, sync_lvl[5:0]})
   );                                                       // R19

   odpc_sync #(.W(1)) u_sync_id
   (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (id_pin_level),
      .sync_out (sync_lvl[6])
   );                                                       // R19

   odpc_por u_por
   (
      .hclk                (hclk),
      .hresetn             (hresetn),
      .vcc3v3_above        (sync_por),
      .supply_ramp_reset_n (supply_ramp_reset_n),
      .phy_reset           (phy_reset)
   );                                                       // R1 R2 R3

   // ---------------------------------------------------------------
   // current otg status
   // ---------------------------------------------------------------
   // id is only meaningful once the sense pull-up is on
   assign id_ok = ctrl_q[`ODPC_CTRL_ID_PU];                 // R5
   // grounded id (a plug) reads 0 per the plug convention
   assign cur[`ODPC_ST_ID_GROUNDED_FLAG]     = id_ok & sync_lvl[6];   // R7
   // valid comparator masked while phy still in reset
   assign cur[`ODPC_ST_VBUS_VALID] = sync_lvl[0] & ~phy_reset; // R10
   assign cur[`ODPC_ST_SESS_VALID] = sync_lvl[1];           // R11
   assign cur[`ODPC_ST_SESSION_END_FLAG]   = sync_lvl[2];           // R12
   assign cur[`ODPC_ST_FAULT]      = sync_lvl[3];           // R17

   // a change is anything differing from what the link last saw
   assign pend = (cur != rep_q) & ~phy_reset;               // R6 R20

   assign mode      = ctrl_q[`ODPC_CTRL_MODE_HI:`ODPC_CTRL_MODE_LO];
   assign sync_mode = (mode == `ODPC_MODE_SYNC);            // R15
   assign lp_mode   = (mode == `ODPC_MODE_LOWPWR);          // R15
   // link idle means all data lines low and no stop
   assign link_idle = (ulpi_data_in == 8'h00) & ~stp;       // R14

   // rx cmd: linestate, vbus band, id grounded
   assign rx_byte = {1'b0, cur[`ODPC_ST_ID_GROUNDED_FLAG], 2'h0,
                     cur[`ODPC_ST_VBUS_VALID],
                     cur[`ODPC_ST_SESS_VALID] |
                     cur[`ODPC_ST_VBUS_VALID],
                     sync_lvl[5:4]};

   // ---------------------------------------------------------------
   // ahb-lite slave, zero wait states
   // ---------------------------------------------------------------
   assign acc      = hsel & hready & htrans[1];
   assign wr_ctrl  = wr_q & is_ofs(ofs_q, `ODPC_OFS_CTRL);
   assign wr_cmd   = wr_q & is_ofs(ofs_q, `ODPC_OFS_CMD);
   assign link_rst = wr_cmd & hwdata[`ODPC_CMD_LINK_RST];   // R4
   assign int_clr  = wr_cmd & hwdata[`ODPC_CMD_INT_CLR];

   // read data captured at address phase for the data phase
   always @*
   begin
      rdata_d = 32'h0000_0000;
      if (is_ofs(haddr[7:0], `ODPC_OFS_CTRL))
         rdata_d[`ODPC_CTRL_W-1:0] = ctrl_q;
      else if (is_ofs(haddr[7:0], `ODPC_OFS_STATUS))
      begin
         rdata_d[`ODPC_ST_W-1:0] = cur;
         rdata_d[`ODPC_ST_PHY_RST] = phy_reset;
         rdata_d[`ODPC_ST_SUPPLY_RAMP_RESET_N]    = supply_ramp_reset_n;
         rdata_d[`ODPC_ST_INT]     = int_q;
         rdata_d[`ODPC_ST_PEND]    = pend;
      end
      else if (is_ofs(haddr[7:0], `ODPC_OFS_REPORTED))
         rdata_d[`ODPC_ST_W-1:0] = rep_q;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_q    <= 1'b0;
         ofs_q   <= 8'h00;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         wr_q <= acc & hwrite;
         if (acc)
            ofs_q <= haddr[7:0];
         if (acc & ~hwrite)
            rdata_q <= rdata_d;
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ---------------------------------------------------------------
   // control register
   // ---------------------------------------------------------------
   always @*
   begin
      ctrl_d = ctrl_q;
      if (link_rst)
         ctrl_d = `ODPC_CTRL_RESET;
      else if (wr_ctrl)
         ctrl_d = hwdata[`ODPC_CTRL_W-1:0];
   end

   // ---------------------------------------------------------------
   // reporting engine: rx cmd in sync mode, interrupt otherwise
   // ---------------------------------------------------------------
   always @*
   begin
      st_d = st_q;
      case (st_q)
         S_IDLE:
            if (pend & sync_mode & link_idle & ~chip_select_n)
               st_d = S_TURN;                               // R6
         S_TURN:
            // stop from the link aborts before the byte goes out
            if (stp)
               st_d = S_IDLE;
            else
               st_d = S_CMD;
         S_CMD:
            st_d = S_BACK;
         S_BACK:
            st_d = S_IDLE;
         default:
            st_d = S_IDLE;
      endcase
   end

   // snapshot taken with the byte, so a later change is not swallowed
   assign rep_set = ((st_q == S_TURN) & ~stp & ~phy_reset) |
                    (pend & ~sync_mode & (st_q == S_IDLE)); // R20

   always @*
   begin
      rep_d = rep_q;
      if (link_rst)
         rep_d = {`ODPC_ST_W{1'b0}};
      else if (rep_set)
         rep_d = cur;
   end

   // set wins over a same-cycle clear
   always @*
   begin
      int_d = int_q;
      if (int_clr | link_rst)
         int_d = 1'b0;
      if (pend & ~sync_mode & (st_q == S_IDLE))
         int_d = 1'b1;                                      // R6 R20
   end

   always @*
   begin
      dout_d = 8'h00;
      if (st_d == S_CMD)
         dout_d = rx_byte;
      else if (lp_mode)
         dout_d = {4'h0, int_q, 1'b0, sync_lvl[5:4]};       // R15
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_q    <= `ODPC_CTRL_RESET;
         rep_q     <= {`ODPC_ST_W{1'b0}};
         int_q     <= 1'b0;
         st_q      <= S_IDLE;
         dout_q    <= 8'h00;
         lp_turn_q <= 1'b0;
      end
      else
      begin
         ctrl_q    <= ctrl_d;
         rep_q     <= rep_d;
         int_q     <= int_d;
         st_q      <= phy_reset ? S_IDLE : st_d;
         dout_q    <= dout_d;
         // one turnaround cycle after dir rises for low power
         lp_turn_q <= lp_mode & ~phy_reset;
      end
   end

   // ---------------------------------------------------------------
   // ulpi pin drive
   // ---------------------------------------------------------------
   // dir high blocks the link during reset and low power
   assign dir_out = phy_reset | lp_mode |
                    (st_q == S_TURN) | (st_q == S_CMD);
   assign nxt_out = 1'b0;
   assign ulpi_data_out = dout_q;
   // data driven only after a turnaround and while selected
   assign ulpi_data_oe_n = chip_select_n |
                           ~((st_q == S_CMD) |
                             (lp_mode & lp_turn_q));        // R16
   assign dir_oe_n = chip_select_n;                         // R16
   assign nxt_oe_n = chip_select_n;                         // R16

   // ---------------------------------------------------------------
   // analog controls
   // ---------------------------------------------------------------
   assign id_sense_pullup_enable = ctrl_q[`ODPC_CTRL_ID_PU]; // R5
   assign id_weak_pullup_enable  = ~ctrl_q[`ODPC_CTRL_ID_PU]; // R9
   // bleed and precharge order is left to the link software
   assign vbus_bleed_enable     = ctrl_q[`ODPC_CTRL_BLEED];  // R13
   assign vbus_precharge_enable = ctrl_q[`ODPC_CTRL_PRECHG]; // R13
   // fault drops the switch at once rather than waiting for software
   assign vbus_switch_enable_out = ctrl_q[`ODPC_CTRL_EXT_DRV] &
                                   ~cur[`ODPC_ST_FAULT] &
                                   ~phy_reset;              // R17 R18
   assign status_int = int_q;

endmodule

// [tb/odpc_monitor.sv]
// concurrent checks on the otg detect and reset block ports
`timescale 1ns/1ps
module odpc_monitor
(
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // bus and comparators
   input logic hreadyout,
   input logic hresp,
   input logic vcc3v3_above_por,
   input logic id_pin_level,
   input logic fault_in,
   // ulpi pins
   input logic chip_select_n,
   input logic ulpi_data_oe_n,
   input logic dir_out,
   input logic dir_oe_n,
   input logic nxt_oe_n,
   // controls and resets
   input logic id_sense_pullup_enable,
   input logic id_weak_pullup_enable,
   input logic vbus_switch_enable_out,
   input logic supply_ramp_reset_n,
   input logic phy_reset
);
   // ----
   // helper: cycles since supply-ramp reset went high
   // ----
   logic [10:0] up_q;

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         up_q <= 11'h000;
      else if (!supply_ramp_reset_n)
         up_q <= 11'h000;
      else if (up_q != 11'h7FF)
         up_q <= up_q + 11'h001;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ----
   // assertions
   // ----
   a_bus_okay_ready: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   a_weak_pullup: assert property (
      id_weak_pullup_enable == !id_sense_pullup_enable)
      else $error("weak id pull-up not inverse of sense pull-up");
   a_cs_tristate: assert property (chip_select_n |->
      ulpi_data_oe_n && dir_oe_n && nxt_oe_n)
      else $error("pins driven while deselected");
   a_por_follows: assert property (
      !vcc3v3_above_por |-> ##3 !supply_ramp_reset_n)
      else $error("ramp reset not low after comparator low");
   a_phy_hold: assert property (
      supply_ramp_reset_n && up_q < 11'h3E7 |-> phy_reset)
      else $error("phy reset released too early");
   a_phy_restart: assert property (
      !supply_ramp_reset_n |-> ##2 phy_reset)
      else $error("phy reset not held during ramp reset");
   a_switch_fault: assert property (
      fault_in [*3] |-> !vbus_switch_enable_out)
      else $error("switch output on during fault");
   a_switch_phy: assert property (
      phy_reset |-> !vbus_switch_enable_out)
      else $error("switch output on during phy reset");
   a_rxcmd_turn: assert property (
      $rose(dir_out) && !chip_select_n |-> ulpi_data_oe_n)
      else $error("data driven without turnaround");
   a_id_deadline: assert property ($changed(id_pin_level) &&
      id_sense_pullup_enable && !phy_reset && !chip_select_n
      |-> ##[1:12] dir_out)
      else $error("id change not reported in time");
endmodule

bind odpc_top odpc_monitor mon_u (.hclk, .hresetn, .hreadyout, .hresp,
   .vcc3v3_above_por, .id_pin_level, .fault_in, .chip_select_n,
   .ulpi_data_oe_n, .dir_out, .dir_oe_n, .nxt_oe_n,
   .id_sense_pullup_enable, .id_weak_pullup_enable,
   .vbus_switch_enable_out, .supply_ramp_reset_n, .phy_reset);

// [tb/odpc_link_model.sv]
// link controller model on the ulpi data pins
`timescale 1ns/1ps
module odpc_link_model
(
   // clock
   input  logic       hclk,
   // device side
   input  logic       dir_out,
   input  logic       ulpi_data_oe_n,
   input  logic [7:0] ulpi_data_out,
   // bench request to stop the next report in its turnaround
   input  logic       abort,
   // resolved wire and stop
   output logic [7:0] ulpi_data_in,
   output logic       stp,
   // captured status bytes
   output logic [7:0] rx_byte,
   output int         rx_count
);
   logic       turn_q;
   logic [7:0] last_q;

   // idle link drives zero; released lines show inverse of last level
   assign ulpi_data_in = !ulpi_data_oe_n ? ulpi_data_out :
                         (dir_out ? ~last_q : 8'h00);
   assign stp = abort && dir_out && ulpi_data_oe_n;

   initial
   begin
      rx_byte = 8'h00;
      rx_count = 0;
      turn_q = 1'b0;
      last_q = 8'h00;
   end

   // a status byte is the first driven cycle after a turnaround
   always @(posedge hclk)
   begin
      last_q <= ulpi_data_in;
      turn_q <= dir_out && ulpi_data_oe_n;
      if (turn_q && dir_out && !ulpi_data_oe_n)
      begin
         rx_byte <= ulpi_data_out;
         rx_count <= rx_count + 1;
      end
   end
endmodule

// [tb/tb.sv]
// self-checking bench for the otg detect and reset block
`timescale 1ns/1ps
`include "odpc_regs.vh"
module tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0]  htrans = 2'h0, linestate = 2'h1;
   logic        vcc3v3_above_por = 1'b0, id_pin_level = 1'b0;
   logic        vbus_valid_cmp = 1'b0, sess_valid_cmp = 1'b0;
   logic        session_end_flag_cmp = 1'b0, fault_in = 1'b0;
   logic        chip_select_n = 1'b0;
   logic [7:0]  ulpi_data_in, ulpi_data_out, rx_byte;
   logic        hreadyout, hresp, ulpi_data_oe_n, dir_out, dir_oe_n;
   logic        nxt_oe_n, id_sense_pullup_enable, id_weak_pullup_enable;
   logic        vbus_bleed_enable, vbus_precharge_enable, stp;
   logic        vbus_switch_enable_out, supply_ramp_reset_n;
   logic        phy_reset, status_int, nxt_out, abort = 1'b0;
   int          rx_count, err_count = 0, n_compared = 0, cyc = 0, n;

   always #20 hclk = ~hclk;

   odpc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .vcc3v3_above_por(vcc3v3_above_por), .id_pin_level(id_pin_level),
      .vbus_valid_cmp(vbus_valid_cmp), .sess_valid_cmp(sess_valid_cmp),
      .session_end_flag_cmp(session_end_flag_cmp), .fault_in(fault_in),
      .linestate(linestate), .chip_select_n(chip_select_n), .stp(stp),
      .ulpi_data_in(ulpi_data_in), .ulpi_data_out(ulpi_data_out),
      .ulpi_data_oe_n(ulpi_data_oe_n), .dir_out(dir_out),
      .dir_oe_n(dir_oe_n), .nxt_out(nxt_out), .nxt_oe_n(nxt_oe_n),
      .id_sense_pullup_enable(id_sense_pullup_enable),
      .id_weak_pullup_enable(id_weak_pullup_enable),
      .vbus_bleed_enable(vbus_bleed_enable),
      .vbus_precharge_enable(vbus_precharge_enable),
      .vbus_switch_enable_out(vbus_switch_enable_out),
      .supply_ramp_reset_n(supply_ramp_reset_n),
      .phy_reset(phy_reset), .status_int(status_int));

   odpc_link_model link_u (.hclk(hclk), .dir_out(dir_out),
      .ulpi_data_oe_n(ulpi_data_oe_n), .ulpi_data_out(ulpi_data_out),
      .ulpi_data_in(ulpi_data_in), .stp(stp), .rx_byte(rx_byte),
      .rx_count(rx_count), .abort(abort));

   // ----
   // tasks
   // ----
   task end_of_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // single word transfer; waits on ready, no fixed latency assumed
   task ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_of_test();
      end
   end

   // ----
   // main sequence
   // ----
   initial
   begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(supply_ramp_reset_n, 1'b0);
      chk(id_weak_pullup_enable, 1'b1);
      ahb(1'b1, `ODPC_OFS_CMD, 32'h1);
      ahb(1'b0, `ODPC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      vcc3v3_above_por <= 1'b1;
      vbus_valid_cmp <= 1'b1;
      repeat (8) @(posedge hclk);
      chk(supply_ramp_reset_n, 1'b1);
      ahb(1'b0, `ODPC_OFS_STATUS, 32'h0);
      chk({rd[6:5], rd[1]}, 3'h6);
      vbus_valid_cmp <= 1'b0;
      n = 0;
      while (phy_reset === 1'b1 && n < 1100)
      begin
         @(posedge hclk);
         n++;
      end
      chk(n > 960 && n < 1100, 1'b1);
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h1);
      repeat (2) @(posedge hclk);
      chk({id_sense_pullup_enable, id_weak_pullup_enable}, 2'h2);
      id_pin_level <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(rx_count, 1);
      chk(rx_byte, 8'h41);
      sess_valid_cmp <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(rx_byte, 8'h45);
      abort <= 1'b1;
      vbus_valid_cmp <= 1'b1;
      repeat (20) @(posedge hclk);
      chk(rx_count, 2);
      abort <= 1'b0;
      repeat (20) @(posedge hclk);
      chk(rx_byte, 8'h4D);
      chk(rx_count, 3);
      ahb(1'b0, `ODPC_OFS_STATUS, 32'h0);
      chk(rd[3:0], 4'h7);
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h9);
      repeat (2) @(posedge hclk);
      chk(vbus_switch_enable_out, 1'b1);
      fault_in <= 1'b1;
      vbus_valid_cmp <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(vbus_switch_enable_out, 1'b0);
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h1);
      fault_in <= 1'b0;
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h3);
      session_end_flag_cmp <= 1'b1;
      do ahb(1'b0, `ODPC_OFS_STATUS, 32'h0); while (rd[3] !== 1'b1);
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h7);
      repeat (2) @(posedge hclk);
      chk({vbus_bleed_enable, vbus_precharge_enable}, 2'h3);
      chip_select_n <= 1'b1;
      repeat (2) @(posedge hclk);
      chk({ulpi_data_oe_n, dir_oe_n, nxt_oe_n}, 3'h7);
      chip_select_n <= 1'b0;
      repeat (20) @(posedge hclk);
      // low power: interrupt flag instead of a status byte
      ahb(1'b1, `ODPC_OFS_CTRL, 32'h11);
      repeat (4) @(posedge hclk);
      id_pin_level <= 1'b0;
      repeat (10) @(posedge hclk);
      chk(status_int, 1'b1);
      chk(ulpi_data_in[3], 1'b1);
      chk(nxt_out, 1'b0);
      ahb(1'b1, `ODPC_OFS_CMD, 32'h2);
      repeat (2) @(posedge hclk);
      chk(status_int, 1'b0);
      for (int m = 0; m < 4; m++)
      begin
         ahb(1'b1, `ODPC_OFS_CTRL, 32'h1 | (m << 4));
         ahb(1'b0, `ODPC_OFS_CTRL, 32'h0);
         chk(rd, 32'h1 | (m << 4));
      end
      ahb(1'b0, 32'h10, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, `ODPC_OFS_CMD, 32'h1);
      ahb(1'b0, `ODPC_OFS_CTRL, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule
